// File: hw/pin_mux_consts.svh
/*
 * Pad indices, field positions and codes, remap bits for the pin mux.
 * Assumes inclusion by bare name.
 */
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// Pad index within the six-pad vectors
`define PAD_A2 0
`define PAD_A3 1
`define PAD_A4 2
`define PAD_A5 3
`define PAD_A6 4
`define PAD_B1 5
`define PAD_COUNT 6

// Config field positions (low bit of each 4-bit field)
`define FLD_A2_LO 8
`define FLD_A3_LO 12
`define FLD_A4_LO 0
`define FLD_A5_LO 4
`define FLD_A6_LO 8
`define FLD_B1_LO 4

// Per-pin config field codes
`define CFG_ANALOG 4'h0
`define CFG_GP_OUT 4'h1
`define CFG_GP_OD 4'h5
`define CFG_ALT_OUT 4'h9
`define CFG_ALT_OD 4'hd

// Timer-2 remap bit positions
`define REMAP_CH1 4
`define REMAP_CH2 5
`define REMAP_CH4 7

// Timer output enable positions (channel n at bit n-1)
`define T2_CH1_OE 0
`define T2_CH2_OE 1
`define T2_CH4_OE 3
`define T1_CH3_OE 2

// SPI config master bit
`define SPI_MASTER_BIT 4

// Edges after reset release before the strap is taken
`define STRAP_SETTLE_EDGES 2'h3

`endif

// File: hw/pin_mux_pkg.sv
/*
 * Types for the shared pin function select block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pin_mux_pkg;

    // Serial controller mode selection
    typedef enum logic [1:0] {
        SER_OFF  = 2'b00,
        SER_UART = 2'b01,
        SER_SPI  = 2'b10,
        SER_TWI  = 2'b11
    } ser_mode_t;

    // Boot strap capture sequence
    typedef enum logic [1:0] {
        STRAP_SETTLE = 2'b00,
        STRAP_TAKE   = 2'b01,
        STRAP_DONE   = 2'b10
    } strap_state_t;

endpackage : pin_mux_pkg

// File: hw/shared_pin_function_select.sv
/*
 * Alternate function selection for six shared pads: port A lines two
 * to six and port B line one, plus the boot strap sample on line five.
 * Assumes the pad cells resolve out/oe into the pin level and return
 * the pin level asynchronously; all control inputs are on mclk.
 */
// Overview of operation
// - Timer-2 ch4 on A2 when remap7 clear
// - Ctrl2 TWI clock open-drain on A2
// - Ctrl2 SPI clock out master, in slave
// - Ctrl2 slave select from A3 in slave
// - CPU trace clock on A3 when enabled
// - Timer-2 ch2 on A3 when remap5 clear
// - A4 to analog input four when analog
// - Packet trace frame on A4, trace off
// - Trace data bit two on A4, four-wire
// - A5 to analog input five when analog
// - Packet trace data on A5, trace off
// - Boot strap on A5 sampled after reset
// - Trace data bit three on A5, four-wire
// - Timer-1 ch3 out on A6 when enabled
// - Timer-1 ch3 input always from A6
// - Ctrl1 slave data out on B1
// - Ctrl1 master data out on B1
// - Ctrl1 TWI data open-drain on B1
// - Ctrl1 UART transmit on B1
// - Timer-2 ch1 out on B1 when remap4 set
`timescale 1ns/1ns
`include "pin_mux_consts.svh"

module shared_pin_function_select
    import pin_mux_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pad configuration words
    input wire logic [15:0] port_a_low_config,
    input wire logic [15:0] port_a_high_config,
    input wire logic [15:0] port_b_low_config,
    // Timer controls
    input wire logic [7:0] timer_two_remap_bits,
    input wire logic [3:0] timer_two_output_enables,
    input wire logic [3:0] timer_one_output_enables,
    // Serial controller controls
    input wire logic [1:0] ctrl1_mode_select,
    input wire logic [7:0] ctrl1_spi_config,
    input wire logic [1:0] ctrl2_mode_select,
    input wire logic [7:0] ctrl2_spi_config,
    // Trace controls
    input wire logic cpu_trace_enable,
    input wire logic cpu_trace_four_wire,
    input wire logic packet_trace_enable,
    // Peripheral output sources
    input wire logic timer_two_channel_four,
    input wire logic timer_two_channel_two,
    input wire logic timer_two_channel_one,
    input wire logic timer_one_channel_three,
    input wire logic ctrl2_twowire_clock,
    input wire logic ctrl2_spi_clock,
    input wire logic cpu_trace_clock,
    input wire logic cpu_trace_bit_two,
    input wire logic cpu_trace_bit_three,
    input wire logic packet_trace_frame,
    input wire logic packet_trace_serial_data,
    input wire logic ctrl1_slave_out_line,
    input wire logic ctrl1_master_out_line,
    input wire logic ctrl1_twowire_data,
    input wire logic ctrl1_uart_transmit,
    // General-purpose data, one bit per pad
    input wire logic [5:0] gpio_out,
    output logic [5:0] gpio_in,
    // Pad cell side, one bit per pad
    input wire logic [5:0] pad_in,
    output logic [5:0] pad_out,
    output logic [5:0] pad_oe,
    // Analog switch enables
    output logic analog_input_four,
    output logic analog_input_five,
    // Peripheral input returns
    output logic timer_two_channel_four_in,
    output logic timer_two_channel_two_in,
    output logic timer_one_channel_three_in,
    output logic ctrl2_twowire_clock_in,
    output logic ctrl2_spi_clock_in,
    output logic ctrl2_slave_select_n,
    output logic ctrl1_twowire_data_in,
    // Boot strap result
    output logic factory_monitor,
    output logic strap_valid
);

    // Reset release chain
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_i_n;

    // Pad input synchronisers
    logic [5:0] pin_meta_q;
    logic [5:0] pin_q;

    // Per-pad config fields
    logic [3:0] fld [`PAD_COUNT];

    // Per-pad decoded drive
    logic [5:0] alt_use;
    logic [5:0] alt_val;
    logic [5:0] alt_od;
    logic [5:0] out_d;
    logic [5:0] oe_d;

    // Decoded conditions
    ser_mode_t mode1;
    ser_mode_t mode2;
    logic ctrl2_master;
    logic ctrl1_master;
    logic ctrl2_free;
    logic trace_clk_free;
    logic ctrl1_free;

    // Strap capture
    strap_state_t strap_state_q;
    logic [1:0] settle_q;

    // Reset synchroniser: only a constant enters under reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_i_n = rst_sync_q;

    // Field extraction
    assign fld[`PAD_A2] = port_a_low_config[`FLD_A2_LO +: 4];
    assign fld[`PAD_A3] = port_a_low_config[`FLD_A3_LO +: 4];
    assign fld[`PAD_A4] = port_a_high_config[`FLD_A4_LO +: 4];
    assign fld[`PAD_A5] = port_a_high_config[`FLD_A5_LO +: 4];
    assign fld[`PAD_A6] = port_a_high_config[`FLD_A6_LO +: 4];
    assign fld[`PAD_B1] = port_b_low_config[`FLD_B1_LO +: 4];

    // Mode and ownership decode
    assign mode1 = ser_mode_t'(ctrl1_mode_select);
    assign mode2 = ser_mode_t'(ctrl2_mode_select);
    assign ctrl2_master = ctrl2_spi_config[`SPI_MASTER_BIT];
    assign ctrl1_master = ctrl1_spi_config[`SPI_MASTER_BIT];
    // Ctrl2 owns line two only if timer-2 ch4 is off or remapped away
    assign ctrl2_free = !timer_two_output_enables[`T2_CH4_OE]
        || timer_two_remap_bits[`REMAP_CH4];
    // Trace clock needs timer-2 ch2 off or remapped away
    assign trace_clk_free = !timer_two_output_enables[`T2_CH2_OE]
        || timer_two_remap_bits[`REMAP_CH2];
    // Ctrl1 needs timer-2 ch1 off or not remapped onto line one
    assign ctrl1_free = !timer_two_output_enables[`T2_CH1_OE]
        || !timer_two_remap_bits[`REMAP_CH1];

    // Alternate function per pad; timers win where two could claim a pad
    always_comb begin
        alt_use = 6'h00;
        alt_val = 6'h00;
        alt_od = 6'h00;
        // Port A line two
        if (!timer_two_remap_bits[`REMAP_CH4] && timer_two_output_enables[`T2_CH4_OE]
            && fld[`PAD_A2] == `CFG_ALT_OUT) begin
            alt_use[`PAD_A2] = 1'b1;
            alt_val[`PAD_A2] = timer_two_channel_four;
        end else if (ctrl2_free && mode2 == SER_TWI && fld[`PAD_A2] == `CFG_ALT_OD) begin
            alt_use[`PAD_A2] = 1'b1;
            alt_od[`PAD_A2] = 1'b1;
            alt_val[`PAD_A2] = ctrl2_twowire_clock;
        end else if (ctrl2_free && mode2 == SER_SPI && ctrl2_master
            && fld[`PAD_A2] == `CFG_ALT_OUT) begin
            alt_use[`PAD_A2] = 1'b1;
            alt_val[`PAD_A2] = ctrl2_spi_clock;
        end
        // Port A line three
        if (!timer_two_remap_bits[`REMAP_CH2] && timer_two_output_enables[`T2_CH2_OE]
            && fld[`PAD_A3] == `CFG_ALT_OUT) begin
            alt_use[`PAD_A3] = 1'b1;
            alt_val[`PAD_A3] = timer_two_channel_two;
        end else if (trace_clk_free && cpu_trace_enable && fld[`PAD_A3] == `CFG_ALT_OUT) begin
            alt_use[`PAD_A3] = 1'b1;
            alt_val[`PAD_A3] = cpu_trace_clock;
        end
        // Port A line four: trace enable keeps the two traces exclusive
        if (fld[`PAD_A4] == `CFG_ALT_OUT) begin
            if (cpu_trace_enable && cpu_trace_four_wire) begin
                alt_use[`PAD_A4] = 1'b1;
                alt_val[`PAD_A4] = cpu_trace_bit_two;
            end else if (!cpu_trace_enable && packet_trace_enable) begin
                alt_use[`PAD_A4] = 1'b1;
                alt_val[`PAD_A4] = packet_trace_frame;
            end
        end
        // Port A line five
        if (fld[`PAD_A5] == `CFG_ALT_OUT) begin
            if (cpu_trace_enable && cpu_trace_four_wire) begin
                alt_use[`PAD_A5] = 1'b1;
                alt_val[`PAD_A5] = cpu_trace_bit_three;
            end else if (!cpu_trace_enable && packet_trace_enable) begin
                alt_use[`PAD_A5] = 1'b1;
                alt_val[`PAD_A5] = packet_trace_serial_data;
            end
        end
        // Port A line six, high-current pad
        if (timer_one_output_enables[`T1_CH3_OE] && fld[`PAD_A6] == `CFG_ALT_OUT) begin
            alt_use[`PAD_A6] = 1'b1;
            alt_val[`PAD_A6] = timer_one_channel_three;
        end
        // Port B line one
        if (timer_two_remap_bits[`REMAP_CH1] && timer_two_output_enables[`T2_CH1_OE]
            && fld[`PAD_B1] == `CFG_ALT_OUT) begin
            alt_use[`PAD_B1] = 1'b1;
            alt_val[`PAD_B1] = timer_two_channel_one;
        end else if (ctrl1_free && mode1 == SER_TWI && fld[`PAD_B1] == `CFG_ALT_OD) begin
            alt_use[`PAD_B1] = 1'b1;
            alt_od[`PAD_B1] = 1'b1;
            alt_val[`PAD_B1] = ctrl1_twowire_data;
        end else if (ctrl1_free && fld[`PAD_B1] == `CFG_ALT_OUT) begin
            case (mode1)
                SER_SPI: begin
                    alt_use[`PAD_B1] = 1'b1;
                    if (ctrl1_master) begin
                        alt_val[`PAD_B1] = ctrl1_master_out_line;
                    end else begin
                        alt_val[`PAD_B1] = ctrl1_slave_out_line;
                    end
                end
                SER_UART: begin
                    alt_use[`PAD_B1] = 1'b1;
                    alt_val[`PAD_B1] = ctrl1_uart_transmit;
                end
                default: begin
                    alt_use[`PAD_B1] = 1'b0;
                end
            endcase
        end
    end

    // Pad drive: alternate, else general-purpose, else released
    genvar gi;
    generate
        for (gi = 0; gi < `PAD_COUNT; gi++) begin : g_pad
            always_comb begin
                if (alt_use[gi]) begin
                    // Open-drain pulls low only; high comes from the bus pull-up
                    out_d[gi] = alt_od[gi] ? 1'b0 : alt_val[gi];
                    oe_d[gi] = alt_od[gi] ? !alt_val[gi] : 1'b1;
                end else if (fld[gi] == `CFG_GP_OUT) begin
                    out_d[gi] = gpio_out[gi];
                    oe_d[gi] = 1'b1;
                end else if (fld[gi] == `CFG_GP_OD) begin
                    out_d[gi] = 1'b0;
                    oe_d[gi] = !gpio_out[gi];
                end else begin
                    // Inputs, analog, and alternate codes with no owner leave the pad released
                    out_d[gi] = 1'b0;
                    oe_d[gi] = 1'b0;
                end
            end

            // Two-stage pin synchroniser; only the second stage is read
            always_ff @(posedge mclk or negedge rst_i_n) begin
                if (!rst_i_n) begin
                    pin_meta_q[gi] <= 1'b1;
                    pin_q[gi] <= 1'b1;
                end else begin
                    pin_meta_q[gi] <= pad_in[gi];
                    pin_q[gi] <= pin_meta_q[gi];
                end
            end

            // Registered pad drive, released in reset
            always_ff @(posedge mclk or negedge rst_i_n) begin
                if (!rst_i_n) begin
                    pad_out[gi] <= 1'b0;
                    pad_oe[gi] <= 1'b0;
                    gpio_in[gi] <= 1'b1;
                end else begin
                    pad_out[gi] <= out_d[gi];
                    pad_oe[gi] <= oe_d[gi];
                    gpio_in[gi] <= pin_q[gi];
                end
            end
        end
    endgenerate

    // Analog switch enables; the digital path stays released meanwhile
    always_ff @(posedge mclk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            analog_input_four <= 1'b0;
            analog_input_five <= 1'b0;
        end else begin
            analog_input_four <= fld[`PAD_A4] == `CFG_ANALOG;
            analog_input_five <= fld[`PAD_A5] == `CFG_ANALOG;
        end
    end

    // Peripheral input returns; unrouted inputs rest at their idle level
    always_ff @(posedge mclk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            timer_two_channel_four_in <= 1'b0;
            timer_two_channel_two_in <= 1'b0;
            timer_one_channel_three_in <= 1'b0;
            ctrl2_twowire_clock_in <= 1'b1;
            ctrl2_spi_clock_in <= 1'b0;
            ctrl2_slave_select_n <= 1'b1;
            ctrl1_twowire_data_in <= 1'b1;
        end else begin
            timer_two_channel_four_in <= !timer_two_remap_bits[`REMAP_CH4]
                && pin_q[`PAD_A2];
            timer_two_channel_two_in <= !timer_two_remap_bits[`REMAP_CH2]
                && pin_q[`PAD_A3];
            // No remap exists, so the pin is always the source
            timer_one_channel_three_in <= pin_q[`PAD_A6];
            ctrl2_twowire_clock_in <= (mode2 == SER_TWI) ? pin_q[`PAD_A2] : 1'b1;
            ctrl2_spi_clock_in <= (mode2 == SER_SPI && !ctrl2_master)
                && pin_q[`PAD_A2];
            ctrl2_slave_select_n <= (mode2 == SER_SPI && !ctrl2_master)
                ? pin_q[`PAD_A3] : 1'b1;
            ctrl1_twowire_data_in <= (mode1 == SER_TWI) ? pin_q[`PAD_B1] : 1'b1;
        end
    end

    // Strap capture: let the syncs refill after release, then take line five once
    always_ff @(posedge mclk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            strap_state_q <= STRAP_SETTLE;
            settle_q <= 2'h0;
            factory_monitor <= 1'b0;
            strap_valid <= 1'b0;
        end else begin
            case (strap_state_q)
                STRAP_SETTLE: begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == `STRAP_SETTLE_EDGES - 2'h1) begin
                        strap_state_q <= STRAP_TAKE;
                    end
                end
                STRAP_TAKE: begin
                    // Active-low strap: a low level selects the factory monitor
                    factory_monitor <= !pin_q[`PAD_A5];
                    strap_valid <= 1'b1;
                    strap_state_q <= STRAP_DONE;
                end
                STRAP_DONE: begin
                    // Held until the next reset; later pin activity is ignored
                    strap_state_q <= STRAP_DONE;
                end
                default: begin
                    strap_state_q <= STRAP_SETTLE;
                end
            endcase
        end
    end

endmodule : shared_pin_function_select

// File: testbench/pad_far_side.sv
/* Far side of the six pads: external drivers and board pull-ups.
   Assumes the pad drive wins over a series-resistor driver. */
`timescale 1ns/1ns
module pad_far_side (
    // Pad cell side of the block
    input wire logic [5:0] pad_out,
    input wire logic [5:0] pad_oe,
    // External drivers
    input wire logic [5:0] ext_val,
    input wire logic [5:0] ext_en,
    // Level back at the block
    output logic [5:0] pad_in
);
    // A released, undriven line floats up, so no stale level survives;
    // the boot strap line reads high unless a part holds it low
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else begin
                pad_in[i] = ext_en[i] ? ext_val[i] : 1'b1;
            end
        end
    end
endmodule : pad_far_side

// File: testbench/pin_mux_sva.sv
/* Checker for the shared pin function select block.
   Sees only the top module's ports; bound to it at the foot. */
`timescale 1ns/1ns
module pin_mux_sva
    import pin_mux_pkg::*;
(
    // Clock and reset
    input logic mclk,
    input logic rst_n,
    // Configuration
    input logic [15:0] port_a_low_config,
    input logic [15:0] port_a_high_config,
    input logic [15:0] port_b_low_config,
    input logic [7:0] timer_two_remap_bits,
    input logic [3:0] timer_two_output_enables,
    input logic [3:0] timer_one_output_enables,
    input logic [1:0] ctrl1_mode_select,
    input logic [1:0] ctrl2_mode_select,
    input logic [7:0] ctrl2_spi_config,
    // Sources
    input logic timer_two_channel_four,
    input logic timer_two_channel_one,
    input logic timer_one_channel_three,
    input logic ctrl2_twowire_clock,
    input logic ctrl1_uart_transmit,
    input logic [5:0] gpio_out,
    // Pads and returns
    input logic [5:0] pad_in,
    input logic [5:0] pad_out,
    input logic [5:0] pad_oe,
    input logic analog_input_four,
    input logic ctrl2_slave_select_n,
    input logic factory_monitor,
    input logic strap_valid
);
    // Edges since reset rose; outputs live from the third
    logic [1:0] up_q;
    logic live, a2_free, b1_free;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    assign live = (up_q == 2'h3);
    // Timer channel not claiming the line
    assign a2_free = !timer_two_output_enables[3] || timer_two_remap_bits[7];
    assign b1_free = !timer_two_output_enables[0] || !timer_two_remap_bits[4];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Slave mode with a steady line three, long enough to pass the syncs
    sequence sel_held;
        (live && ctrl2_mode_select == SER_SPI && !ctrl2_spi_config[4] && $stable(pad_in[1])) [*4];
    endsequence
    // Reset just let go
    sequence released;
        $rose(rst_n);
    endsequence
    timer_ch4_a: assert property (
        live && port_a_low_config[11:8] == 4'h9 && !timer_two_remap_bits[7] && timer_two_output_enables[3]
        |=> pad_oe[0] && pad_out[0] == $past(timer_two_channel_four)) else $error("line two lost channel four");
    twowire_clock_a: assert property (
        live && ctrl2_mode_select == SER_TWI && port_a_low_config[11:8] == 4'hd && a2_free
        |=> !pad_out[0] && pad_oe[0] == !$past(ctrl2_twowire_clock)) else $error("two-wire clock drive wrong");
    slave_select_a: assert property (
        sel_held |-> ctrl2_slave_select_n == pad_in[1]) else $error("slave select wrong");
    analog_four_a: assert property (
        live && port_a_high_config[3:0] == 4'h0 |=> analog_input_four && !pad_oe[2]) else $error("analog four wrong");
    timer_one_a: assert property (
        live && port_a_high_config[11:8] == 4'h9 && timer_one_output_enables[2]
        |=> pad_oe[4] && pad_out[4] == $past(timer_one_channel_three)) else $error("line six lost timer one");
    uart_drive_a: assert property (
        live && ctrl1_mode_select == SER_UART && port_b_low_config[7:4] == 4'h9 && b1_free
        |=> pad_oe[5] && pad_out[5] == $past(ctrl1_uart_transmit)) else $error("uart transmit missing");
    timer_ch1_a: assert property (
        live && port_b_low_config[7:4] == 4'h9 && timer_two_remap_bits[4] && timer_two_output_enables[0]
        |=> pad_oe[5] && pad_out[5] == $past(timer_two_channel_one)) else $error("line one lost channel one");
    gp_drive_a: assert property (
        live && port_a_high_config[11:8] == 4'h1
        |=> pad_oe[4] && pad_out[4] == $past(gpio_out[4])) else $error("line six plain output wrong");
    strap_soon_a: assert property (
        released |-> ##[1:12] strap_valid) else $error("strap not taken");
    strap_value_a: assert property (
        $rose(strap_valid) |-> factory_monitor == !pad_in[3]) else $error("strap captured wrong");
endmodule : pin_mux_sva

bind shared_pin_function_select pin_mux_sva u_sva (.*);

// File: testbench/shared_pin_function_select_test.sv
/* Bench for the shared pin function select: random routing trials and
   the boot strap over two resets. Assumes far-side model and checker. */
`timescale 1ns/1ns
module shared_pin_function_select_test
    import pin_mux_pkg::*;
;
    // One expected result
    typedef struct {string nm; int id; logic v;} note_t;
    note_t notes [$];
    event check_ev;
    int fail_count, n_compared;
    // Stimulus
    logic mclk, rst_n;
    logic [15:0] cfg_al, cfg_ah, cfg_bl;
    logic [7:0] rmp, c1, c2;
    logic [3:0] t2oe, t1oe;
    logic [1:0] m1, m2;
    logic [2:0] trc;
    logic [14:0] src;
    logic [5:0] gpo, xv, xen;
    // Observed
    logic [5:0] gpio_in, pad_in, pad_out, pad_oe;
    logic an4, an5, t2c4_in, t2c2_in, t1c3_in, scl_in, spi_in, ssel_n, sda_in, fm, sv;
    logic [28:0] obs;
    // Field codes, alternate ones weighted up
    logic [3:0] fc [8] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'hd, 4'h9, 4'hd, 4'h2};
    assign obs = {sda_in, scl_in, t2c2_in, gpio_in, sv, fm, ssel_n, spi_in, t1c3_in, t2c4_in, an5, an4, pad_oe, pad_out};

    shared_pin_function_select u_dut (
        .mclk(mclk), .rst_n(rst_n), .port_a_low_config(cfg_al), .port_a_high_config(cfg_ah),
        .port_b_low_config(cfg_bl), .timer_two_remap_bits(rmp), .timer_two_output_enables(t2oe),
        .timer_one_output_enables(t1oe), .ctrl1_mode_select(m1), .ctrl1_spi_config(c1),
        .ctrl2_mode_select(m2), .ctrl2_spi_config(c2), .cpu_trace_enable(trc[0]),
        .cpu_trace_four_wire(trc[1]), .packet_trace_enable(trc[2]), .timer_two_channel_four(src[0]),
        .timer_two_channel_two(src[1]), .timer_two_channel_one(src[2]), .timer_one_channel_three(src[3]),
        .ctrl2_twowire_clock(src[4]), .ctrl2_spi_clock(src[5]), .cpu_trace_clock(src[6]),
        .cpu_trace_bit_two(src[7]), .cpu_trace_bit_three(src[8]), .packet_trace_frame(src[9]),
        .packet_trace_serial_data(src[10]), .ctrl1_slave_out_line(src[11]), .ctrl1_master_out_line(src[12]),
        .ctrl1_twowire_data(src[13]), .ctrl1_uart_transmit(src[14]), .gpio_out(gpo), .gpio_in(gpio_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .analog_input_four(an4), .analog_input_five(an5),
        .timer_two_channel_four_in(t2c4_in), .timer_two_channel_two_in(t2c2_in),
        .timer_one_channel_three_in(t1c3_in), .ctrl2_twowire_clock_in(scl_in), .ctrl2_spi_clock_in(spi_in),
        .ctrl2_slave_select_n(ssel_n), .ctrl1_twowire_data_in(sda_in), .factory_monitor(fm), .strap_valid(sv)
    );
    pad_far_side u_far (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(xv), .ext_en(xen), .pad_in(pad_in));

    // Clock at 125 MHz
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Verdict and end of run
    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic note(input string nm, input int id, input logic v);
        notes.push_back('{nm, id, v});
    endtask : note

    // Reference {oe, out} of one pad
    function automatic logic [1:0] ref_pad(input int p);
        logic [3:0] f;
        logic tc, ts, oc, os, pc, ps, fa, fb;
        fa = !t2oe[3] || rmp[7];
        fb = !t2oe[0] || !rmp[4];
        {f, tc, ts, oc, os, pc, ps} = '0;
        case (p)
            0: begin
                {f, tc, ts, oc, os} = {cfg_al[11:8], !rmp[7] && t2oe[3], src[0], m2 == SER_TWI && fa, src[4]};
                {pc, ps} = {m2 == SER_SPI && c2[4] && fa, src[5]};
            end
            1: begin
                {f, tc, ts} = {cfg_al[15:12], !rmp[5] && t2oe[1], src[1]};
                {pc, ps} = {trc[0] && (!t2oe[1] || rmp[5]), src[6]};
            end
            2: {f, tc, ts, pc, ps} = {cfg_ah[3:0], trc[0] && trc[1], src[7], !trc[0] && trc[2], src[9]};
            3: {f, tc, ts, pc, ps} = {cfg_ah[7:4], trc[0] && trc[1], src[8], !trc[0] && trc[2], src[10]};
            4: {f, tc, ts} = {cfg_ah[11:8], t1oe[2], src[3]};
            default: begin
                {f, tc, ts, oc, os} = {cfg_bl[7:4], rmp[4] && t2oe[0], src[2], m1 == SER_TWI && fb, src[13]};
                {pc, ps} = {(m1 == SER_UART || m1 == SER_SPI) && fb, m1 == SER_UART ? src[14] : src[11 + c1[4]]};
            end
        endcase
        // Timer first, then two-wire, then the rest, else plain I/O
        return (f == 4'h9 && tc) ? {1'b1, ts} : (f == 4'hd && oc) ? {!os, 1'b0} :
            (f == 4'h9 && pc) ? {1'b1, ps} : (f == 4'h1) ? {1'b1, gpo[p]} :
            (f == 4'h5) ? {!gpo[p], 1'b0} : 2'b00;
    endfunction : ref_pad

    // One random setup; after the pad path and syncs settle, note results
    task automatic trial();
        logic [1:0] e;
        logic [5:0] lv;
        logic sl;
        cfg_al = {fc[$urandom % 8], fc[$urandom % 8], 8'($urandom)};
        cfg_ah = {4'($urandom), fc[$urandom % 8], fc[$urandom % 8], fc[$urandom % 8]};
        cfg_bl = {8'($urandom), fc[$urandom % 8], 4'($urandom)};
        {rmp, c1, c2, t2oe} = 28'($urandom);
        {t1oe, m1, m2, trc, src} = 26'($urandom);
        {gpo, xv, xen} = 18'($urandom);
        repeat (5) @(negedge mclk);
        for (int p = 0; p < 6; p++) begin
            e = ref_pad(p);
            lv[p] = e[1] ? e[0] : (xen[p] ? xv[p] : 1'b1);
            note($sformatf("pad_out[%0d]", p), p, e[0]);
            note($sformatf("pad_oe[%0d]", p), p + 6, e[1]);
            note($sformatf("gpio_in[%0d]", p), p + 20, lv[p]);
        end
        sl = m2 == SER_SPI && !c2[4];
        note("analog_input_four", 12, cfg_ah[3:0] == 4'h0);
        note("analog_input_five", 13, cfg_ah[7:4] == 4'h0);
        note("timer_two_channel_four_in", 14, !rmp[7] && lv[0]);
        note("timer_one_channel_three_in", 15, lv[4]);
        note("ctrl2_spi_clock_in", 16, sl && lv[0]);
        note("ctrl2_slave_select_n", 17, !sl || lv[1]);
        note("t2c2_in", 26, !rmp[5] && lv[1]);
        note("scl_in", 27, m2 != SER_TWI || lv[0]);
        note("sda_in", 28, m1 != SER_TWI || lv[5]);
        -> check_ev;
    endtask : trial

    // Reset with the strap held as asked, then the captured strap
    task automatic boot(input logic strap_low);
        {cfg_al, cfg_ah, cfg_bl} = '0;
        xen = {2'b00, strap_low, 3'b000};
        xv = 6'h00;
        rst_n = 1'b0;
        repeat (12) @(negedge mclk);
        note("pad_oe[5] in reset", 11, 1'b0);
        note("ctrl2_slave_select_n in reset", 17, 1'b1);
        -> check_ev;
        rst_n = 1'b1;
        repeat (12) @(negedge mclk);
        note("strap_valid", 19, 1'b1);
        note("factory_monitor", 18, strap_low);
        -> check_ev;
    endtask : boot

    // Watcher: settle pending notes oldest first
    initial begin
        note_t n;
        forever begin
            @(check_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                n_compared++;
                if (obs[n.id] !== n.v) begin
                    fail_count++;
                    $display("mismatch %s expected %b seen %b", n.nm, n.v, obs[n.id]);
                end
            end
        end
    end

    // Main sequence; the second reset lands mid-run
    initial begin
        {rmp, c1, c2, t2oe, t1oe, m1, m2, trc, src, gpo} = '0;
        fail_count = 0;
        n_compared = 0;
        void'($urandom(38890));
        boot(1'b1);
        repeat (80) trial();
        boot(1'b0);
        repeat (80) trial();
        note("factory_monitor", 18, 1'b0);
        -> check_ev;
        @(negedge mclk);
        finish_test();
    end

    // Watchdog, well past the run length
    initial begin
        repeat (4000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
endmodule : shared_pin_function_select_test
